// ===== hw/lps_pkg.sv
// Purpose: Shared constants and types of the low-power standby/halt sequencer.
// Assumes: One ref_clk cycle stands for one oscillator and one system clock cycle.
// Notes: Counts derive from printed times and the 250 MHz clock rate.
`default_nettype none
package lps_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int CNT_W_DEF = 20;
  // Pipeline flush lengths per divider select
  localparam int unsigned FLUSH_SHORT_CYC = 16;
  localparam int unsigned FLUSH_MID_CYC = 32;
  localparam int unsigned FLUSH_LONG_CYC = 64;
  // External clock output low window after the idle instruction
  localparam int unsigned XCLK_LOW_MIN_CYC = 32;
  localparam int unsigned XCLK_LOW_MAX_CYC = 45;
  localparam int unsigned XCLK_LOW_CYC = (XCLK_LOW_MIN_CYC + XCLK_LOW_MAX_CYC) / 2;
  localparam int XCLK_W = 6;
  // Wake pulse figures, oscillator cycles
  localparam int unsigned WAKE_HOLDOFF_CYC = 5;
  localparam int unsigned UNQUAL_MIN_CYC = 3;
  localparam int unsigned QUAL_BASE_CYC = 2;
  localparam int unsigned HALT_GPIO_EXTRA_CYC = 2;
  localparam int unsigned HALT_RST_EXTRA_CYC = 8;
  localparam int unsigned OSC_START_CYC_DEF = 64;
  // PLL lock time
  localparam int unsigned PLL_LOCK_MS = 1;
  localparam int unsigned PLL_LOCK_CYC_DEF = PLL_LOCK_MS * CLK_MHZ * 1000;
  // Wake to execution limits, system clock cycles
  localparam int unsigned STBY_RESUME_CYC = 100;
  localparam int unsigned FLASH_SLEEP_RESUME_CYC = 1125;
  localparam int unsigned SARAM_HALT_RESUME_CYC = 35;
  localparam int unsigned RESUME_MARGIN_CYC = 4;
  // Controller register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] WIDTH_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam int IDLE_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int KIND_LSB = 2;
  localparam logic [15:0] WIDTH_RST = 16'h0003;
  // Wake source kinds
  localparam logic [1:0] KIND_GPIO = 2'h0;
  localparam logic [1:0] KIND_RST = 2'h1;
  localparam logic [1:0] KIND_INT = 2'h2;
  localparam logic [1:0] KIND_WD = 2'h3;
  typedef enum logic [2:0] {
    st_run, st_flush, st_standby, st_halt, st_osc_start, st_pll_lock, st_resume
  } lps_dev_state_type;
  typedef enum logic [0:0] {h_ready, h_pulse} lps_host_state_type;
endpackage : lps_pkg
`default_nettype wire

// ===== hw/lps_link_if.sv
// Purpose: Link between the sequencer and the CPU/wake-source side.
// Assumes: All signals synchronous to ref_clk.
// Notes: Wake pin and reset pin are active low.
`default_nettype none
interface lps_link_if;
  logic idle_exec;
  logic wake_gpio_n;
  logic device_reset_pin_n;
  logic int_wake;
  logic watchdog_interrupt;
  logic cpu_run;
  logic osc_stable;
  logic external_clock_output;
  modport device (
    input idle_exec, wake_gpio_n, device_reset_pin_n, int_wake, watchdog_interrupt,
    output cpu_run, osc_stable, external_clock_output
  );
  modport host (
    output idle_exec, wake_gpio_n, device_reset_pin_n, int_wake, watchdog_interrupt,
    input cpu_run, osc_stable, external_clock_output
  );
endinterface : lps_link_if
`default_nettype wire

// ===== hw/lps_down_counter.sv
// Purpose: Loadable down counter that stops at zero.
// Assumes: Load has priority over counting.
// Notes: done is high while the count is zero.
`default_nettype none
module lps_down_counter #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  assign cnt_next = load ? load_val : ((cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg);
  assign done = (cnt_reg == '0);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : lps_down_counter
`default_nettype wire

// ===== hw/lps_device.sv
// Purpose: Standby/halt low-power sequencer, device end.
// Assumes: Wake sources obey holdoff, width and release timing.
// Notes: Clock controls are registered and high means running.
// Operation
// - Idle instruction enters the selected low-power mode.
// - Standby keeps system clock 16/32/64 cycles first.
// - Standby gates peripherals, keeps PLL and watchdog.
// - Wake not asserted before 5 oscillator cycles.
// - Standby wake width 3, or 2+count qualified.
// - External clock output low 32 to 45 cycles.
// - Standby resume within 100 or 1125 cycles.
// - Resume at instruction after idle.
// - Wake interrupt serviced after standby only if enabled.
// - Wake source drives glitch-free full-width pulses.
// - Halt GPIO wake lasts start-up plus 2.
// - Halt reset-pin wake lasts start-up plus 8.
// - Halt flushes 16/32/64 cycles, then stops clocks.
// - Halt gates peripherals, PLL, crystal oscillator; crystal only if xtal_source is set.
// - Keep-alive bits hold oscillators and watchdog.
// - GPIO falling edge restarts oscillator in halt.
// - GPIO released only after oscillator stable.
// - PLL lock sequence gets 1 ms.
// - Halt resume within 1125 or 35 cycles.
// - Halt exit services wake interrupt if enabled.
// - Interrupts, watchdog, reset pin also wake.
`default_nettype none
module lps_device #(
  parameter int unsigned OSC_START_CYC = lps_pkg::OSC_START_CYC_DEF,
  parameter int unsigned PLL_LOCK_CYC = lps_pkg::PLL_LOCK_CYC_DEF,
  parameter int CNT_W = lps_pkg::CNT_W_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link to CPU and wake sources
  lps_link_if.device link,
  // Configuration
  input wire logic lpm_select_halt,
  input wire logic [1:0] clock_divider_select,
  input wire logic standby_qual_en,
  input wire logic [5:0] standby_qual_count,
  input wire logic xtal_source,
  input wire logic keep_osc_one,
  input wire logic keep_osc_two,
  input wire logic keep_watchdog,
  input wire logic flash_asleep,
  input wire logic wake_int_enable,
  // Clock controls
  output logic sys_clk_run,
  output logic periph_clk_en,
  output logic pll_en,
  output logic xtal_osc_en,
  output logic core_clock_input_en,
  output logic internal_osc_one_en,
  output logic internal_osc_two_en,
  output logic watchdog_en,
  // Status
  output logic in_standby,
  output logic in_halt,
  output logic wake_irq
);
  import lps_pkg::*;

  lps_dev_state_type state_reg;
  lps_dev_state_type state_next;
  logic halt_mode_reg;
  logic halt_mode_next;
  logic gpio_prev_reg;
  logic [6:0] qual_cnt_reg;
  logic [6:0] qual_cnt_next;
  logic [6:0] qual_need;
  logic [10:0] out_reg;
  logic [10:0] out_next;
  logic xclk_reg;
  logic xclk_next;
  logic wake_irq_reg;
  logic wake_irq_next;
  logic phase_load;
  logic phase_done;
  logic [CNT_W-1:0] phase_val;
  logic [CNT_W-1:0] flush_val;
  logic [CNT_W-1:0] resume_val;
  logic idle_take;
  logic wake_lvl;
  logic stby_wake;
  logic halt_wake;
  logic nx_lp;
  logic nx_halted;
  logic xclk_load;
  logic xclk_done;
  logic xclk_low;

  // Idle accepted only while running; mode latched at that moment
  assign idle_take = (state_reg == st_run) && link.idle_exec;
  assign halt_mode_next = idle_take ? lpm_select_halt : halt_mode_reg;

  // Flush length from divider select
  assign flush_val = (clock_divider_select == 2'h3) ? CNT_W'(FLUSH_LONG_CYC - 1) :
                     (clock_divider_select == 2'h2) ? CNT_W'(FLUSH_MID_CYC - 1) :
                     CNT_W'(FLUSH_SHORT_CYC - 1);

  // Resume latency kept inside the printed limits
  assign resume_val = flash_asleep ? CNT_W'(FLASH_SLEEP_RESUME_CYC - RESUME_MARGIN_CYC) :
                      halt_mode_reg ? CNT_W'(SARAM_HALT_RESUME_CYC - RESUME_MARGIN_CYC) :
                      CNT_W'(STBY_RESUME_CYC - RESUME_MARGIN_CYC);

  // Any wake event, level form
  assign wake_lvl = !link.wake_gpio_n || !link.device_reset_pin_n ||
                    link.int_wake || link.watchdog_interrupt;

  // Standby qualification: any wake source active for 2 plus count consecutive cycles
  assign qual_need = 7'(QUAL_BASE_CYC) + {1'h0, standby_qual_count};
  assign stby_wake = wake_lvl &&
                     (!standby_qual_en || (qual_cnt_reg + 7'h01 >= qual_need));
  assign qual_cnt_next = (state_reg == st_standby && wake_lvl) ? qual_cnt_reg + 7'h01 :
                         7'h00;

  // Halt: falling edge of the wake pin, or other wake sources
  assign halt_wake = (gpio_prev_reg && !link.wake_gpio_n) ||
                     !link.device_reset_pin_n || link.int_wake ||
                     (link.watchdog_interrupt && keep_watchdog);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_run: begin
        if (idle_take) begin
          state_next = st_flush;
        end
      end
      st_flush: begin
        if (phase_done) begin
          state_next = halt_mode_reg ? st_halt : st_standby;
        end
      end
      st_standby: begin
        if (stby_wake) begin
          state_next = st_resume;
        end
      end
      st_halt: begin
        if (halt_wake) begin
          state_next = st_osc_start;
        end
      end
      st_osc_start: begin
        if (phase_done) begin
          state_next = st_pll_lock;
        end
      end
      st_pll_lock: begin
        if (phase_done) begin
          state_next = st_resume;
        end
      end
      st_resume: begin
        if (phase_done) begin
          state_next = st_run;
        end
      end
      default: begin
        state_next = st_run;
      end
    endcase
  end

  // Phase timer reloads on each state change
  assign phase_load = (state_next != state_reg);
  always_comb begin
    case (state_next)
      st_flush: phase_val = flush_val;
      st_osc_start: phase_val = CNT_W'(OSC_START_CYC - 1);
      st_pll_lock: phase_val = CNT_W'(PLL_LOCK_CYC - 1);
      st_resume: phase_val = resume_val;
      default: phase_val = '0;
    endcase
  end

  lps_down_counter #(
    .W(CNT_W)
  ) u_phase (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(phase_load),
    .load_val(phase_val),
    .done(phase_done)
  );

  // External clock output forced low a fixed time after idle
  assign xclk_load = idle_take;
  lps_down_counter #(
    .W(XCLK_W)
  ) u_xclk (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(xclk_load),
    .load_val(XCLK_W'(XCLK_LOW_CYC - 1)),
    .done(xclk_done)
  );
  assign xclk_low = (state_reg != st_run) && xclk_done && !xclk_load;
  assign xclk_next = xclk_low ? 1'h0 : !xclk_reg;

  // Clock controls decoded from the next state
  assign nx_lp = (state_next == st_standby) || nx_halted;
  assign nx_halted = (state_next == st_halt) || (state_next == st_osc_start) ||
                     (state_next == st_pll_lock);
  assign out_next[0] = !nx_lp;
  assign out_next[1] = !nx_lp;
  assign out_next[2] = !nx_halted || (state_next == st_pll_lock);
  assign out_next[3] = !((state_next == st_halt) && xtal_source);
  assign out_next[4] = !nx_halted;
  assign out_next[5] = (state_next != st_halt) || keep_osc_one;
  assign out_next[6] = (state_next != st_halt) || keep_osc_two;
  assign out_next[7] = !nx_halted || keep_watchdog;
  assign out_next[8] = (state_next == st_run);
  assign out_next[9] = !((state_next == st_halt) || (state_next == st_osc_start));
  assign out_next[10] = (state_next == st_standby);

  // Wake interrupt handed on at exit, only when enabled
  assign wake_irq_next = (state_reg == st_resume) && phase_done && wake_int_enable;

  assign sys_clk_run = out_reg[0];
  assign periph_clk_en = out_reg[1];
  assign pll_en = out_reg[2];
  assign xtal_osc_en = out_reg[3];
  assign core_clock_input_en = out_reg[4];
  assign internal_osc_one_en = out_reg[5];
  assign internal_osc_two_en = out_reg[6];
  assign watchdog_en = out_reg[7];
  assign link.cpu_run = out_reg[8];
  assign link.osc_stable = out_reg[9];
  assign in_standby = out_reg[10];
  assign in_halt = halt_mode_reg && !out_reg[8] && !out_reg[10];
  assign link.external_clock_output = xclk_reg;
  assign wake_irq = wake_irq_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= st_run;
      halt_mode_reg <= 1'h0;
      gpio_prev_reg <= 1'h1;
      qual_cnt_reg <= 7'h00;
      out_reg <= 11'h3FF;
      xclk_reg <= 1'h0;
      wake_irq_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      halt_mode_reg <= halt_mode_next;
      gpio_prev_reg <= link.wake_gpio_n;
      qual_cnt_reg <= qual_cnt_next;
      out_reg <= out_next;
      xclk_reg <= xclk_next;
      wake_irq_reg <= wake_irq_next;
    end
  end
endmodule : lps_device
`default_nettype wire

// ===== hw/lps_host.sv
// Purpose: CPU and wake-source end, driven by software registers.
// Assumes: Plain register port, read data one cycle after the strobe.
// Notes: Pulse width is the larger of software width and source minimum.
`default_nettype none
module lps_host #(
  parameter int unsigned OSC_START_CYC = lps_pkg::OSC_START_CYC_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link to the device
  lps_link_if.host link,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import lps_pkg::*;

  lps_host_state_type state_reg;
  lps_host_state_type state_next;
  logic [15:0] width_reg;
  logic [1:0] kind_reg;
  logic go_reg;
  logic go_next;
  logic idle_reg;
  logic [3:0] line_reg;
  logic [3:0] line_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic wr_ctrl;
  logic wr_width;
  logic idle_req;
  logic start;
  logic hold_done;
  logic pulse_done;
  logic release_ok;
  logic [15:0] kind_min;
  logic [15:0] pulse_len;

  assign wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
  assign wr_width = reg_wr && (reg_addr == WIDTH_OFS);
  assign idle_req = wr_ctrl && reg_wdata[IDLE_BIT] && link.cpu_run;

  // Wake held off after idle
  lps_down_counter #(
    .W(4)
  ) u_hold (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(idle_req),
    .load_val(4'(WAKE_HOLDOFF_CYC)),
    .done(hold_done)
  );

  assign start = (state_reg == h_ready) && go_reg && hold_done && !idle_req;
  assign go_next = (wr_ctrl && reg_wdata[GO_BIT]) || (go_reg && !start);

  // Minimum width per source kind
  assign kind_min = (kind_reg == KIND_GPIO) ? 16'(OSC_START_CYC + HALT_GPIO_EXTRA_CYC) :
                    (kind_reg == KIND_RST) ? 16'(OSC_START_CYC + HALT_RST_EXTRA_CYC) :
                    16'(UNQUAL_MIN_CYC);
  assign pulse_len = ((width_reg > kind_min) ? width_reg : kind_min) - 16'h0001;

  lps_down_counter #(
    .W(16)
  ) u_pulse (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load(start),
    .load_val(pulse_len),
    .done(pulse_done)
  );

  // Wake pin released only once the oscillator is stable
  assign release_ok = pulse_done && ((kind_reg != KIND_GPIO) || link.osc_stable);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      h_ready: begin
        if (start) begin
          state_next = h_pulse;
        end
      end
      h_pulse: begin
        if (release_ok) begin
          state_next = h_ready;
        end
      end
      default: begin
        state_next = h_ready;
      end
    endcase
  end

  // One steady level per pulse, no glitches
  genvar k;
  for (k = 0; k < 4; k++) begin : g_line
    assign line_next[k] = (state_next == h_pulse) && (kind_reg == 2'(k));
  end

  assign link.wake_gpio_n = !line_reg[KIND_GPIO];
  assign link.device_reset_pin_n = !line_reg[KIND_RST];
  assign link.int_wake = line_reg[KIND_INT];
  assign link.watchdog_interrupt = line_reg[KIND_WD];
  assign link.idle_exec = idle_reg;

  assign rdata_next = !reg_rd ? 32'h0 :
                      (reg_addr == CTRL_OFS) ? 32'(kind_reg) << KIND_LSB :
                      (reg_addr == WIDTH_OFS) ? {16'h0, width_reg} :
                      (reg_addr == STAT_OFS) ? {27'h0, link.external_clock_output,
                        go_reg, (state_reg == h_pulse), link.osc_stable, link.cpu_run} :
                      32'h0;
  assign reg_rdata = rdata_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= h_ready;
      width_reg <= WIDTH_RST;
      kind_reg <= KIND_GPIO;
      go_reg <= 1'h0;
      idle_reg <= 1'h0;
      line_reg <= 4'h0;
      rdata_reg <= 32'h0;
    end else begin
      state_reg <= state_next;
      width_reg <= wr_width ? reg_wdata[15:0] : width_reg;
      kind_reg <= (wr_ctrl && state_reg == h_ready) ? reg_wdata[KIND_LSB +: 2] : kind_reg;
      go_reg <= go_next;
      idle_reg <= idle_req;
      line_reg <= line_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule : lps_host
`default_nettype wire

// ===== test/lps_chk.sv
// Purpose: Link timing checks of the low-power sequencer.
// Assumes: Both link ends are design modules on ref_clk.
// Notes: Counts follow the parameters handed in by the bench.
`default_nettype none
module lps_chk #(
  parameter int OSC_START_CYC = 4,
  parameter int PLL_LOCK_CYC = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link
  input wire logic idle_exec,
  input wire logic wake_gpio_n,
  input wire logic device_reset_pin_n,
  input wire logic int_wake,
  input wire logic watchdog_interrupt,
  input wire logic cpu_run,
  input wire logic osc_stable,
  input wire logic external_clock_output
);
  localparam int OSC_MAX = OSC_START_CYC + 3;
  localparam int LOCK_MAX = PLL_LOCK_CYC + 1126;
  localparam int WAKE_MAX = OSC_START_CYC + PLL_LOCK_CYC + 1200;
  logic [15:0] gpio_low_reg;
  logic [15:0] pin_low_reg;
  logic [15:0] lock_cnt_reg;
  logic [15:0] wake_cnt_reg;
  logic lock_on_reg;
  logic wake_on_reg;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Low time of each pin wake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_low_reg <= 16'h0000;
      pin_low_reg <= 16'h0000;
      lock_cnt_reg <= 16'h0000;
      wake_cnt_reg <= 16'h0000;
      lock_on_reg <= 1'b0;
      wake_on_reg <= 1'b0;
    end else begin
      gpio_low_reg <= wake_gpio_n ? 16'h0000 : gpio_low_reg + 16'h0001;
      pin_low_reg <= device_reset_pin_n ? 16'h0000 : pin_low_reg + 16'h0001;
      // Cycles from oscillator stable, and from int_wake, up to resume
      lock_on_reg <= !cpu_run && (!osc_stable || lock_on_reg);
      lock_cnt_reg <= cpu_run ? 16'h0000 : lock_cnt_reg + 16'(lock_on_reg && osc_stable);
      wake_on_reg <= !cpu_run && (int_wake || wake_on_reg);
      wake_cnt_reg <= wake_on_reg ? wake_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  idle_stop_a: assert property (idle_exec && cpu_run |=> !cpu_run [*8])
    else $error("idle not taken");
  xclk_low_a: assert property (idle_exec && cpu_run |-> ##45 !external_clock_output [*4])
    else $error("clock output not low");
  holdoff_a: assert property ($rose(idle_exec) |=>
    (wake_gpio_n && device_reset_pin_n && !int_wake && !watchdog_interrupt) [*5])
    else $error("wake too soon");
  width_a: assert property ($rose(int_wake) |-> int_wake [*3])
    else $error("wake pulse short");
  gpio_width_a: assert property ($rose(wake_gpio_n) |-> gpio_low_reg >= 16'(OSC_START_CYC + 2))
    else $error("gpio pulse short");
  pin_width_a: assert property ($rose(device_reset_pin_n) |-> pin_low_reg >= 16'(OSC_START_CYC + 8))
    else $error("pin pulse short");
  osc_start_a: assert property (($fell(wake_gpio_n) || $fell(device_reset_pin_n)) && !osc_stable
    |-> ##[1:OSC_MAX] osc_stable)
    else $error("oscillator not restarted");
  release_a: assert property ($rose(wake_gpio_n) |-> osc_stable)
    else $error("gpio released early");
  lock_resume_a: assert property ($rose(cpu_run) && lock_on_reg |->
    lock_cnt_reg >= 16'(PLL_LOCK_CYC))
    else $error("resume before lock");
  lock_limit_a: assert property (lock_cnt_reg <= 16'(LOCK_MAX))
    else $error("lock to resume too long");
  wake_resume_a: assert property (wake_cnt_reg <= 16'(WAKE_MAX))
    else $error("no resume after wake");
  xclk_early_a: assert property (idle_exec && cpu_run |->
    ##30 $changed(external_clock_output))
    else $error("clock output low too early");
endmodule : lps_chk
`default_nettype wire

// ===== test/test_low_power_standby_halt_sequencer.sv
// Purpose: Self-checking bench of the sequencer with both link ends.
// Assumes: Shortened oscillator start and PLL lock counts.
// Notes: A second device faces the bench directly for qualified wakes.
`default_nettype none
module test_low_power_standby_halt_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  import lps_pkg::*;
  localparam int OSC = 4;
  localparam int PLL = 20;
  localparam int LIMIT = 3000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] clock_divider_select = 2'h0;
  logic [5:0] standby_qual_count = 6'h00;
  logic lpm_select_halt = 1'b0, flash_asleep = 1'b0, wake_int_enable = 1'b0;
  logic keep_osc_one = 1'b0, keep_osc_two = 1'b0, keep_watchdog = 1'b0, xtal_source = 1'b1;
  logic sys_clk_run, periph_clk_en, pll_en, xtal_osc_en, core_clock_input_en;
  logic internal_osc_one_en, internal_osc_two_en, watchdog_en;
  logic in_standby, in_halt, wake_irq, in_standby2;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc_count = 0;
  lps_link_if link();
  lps_link_if lk2();
  wire logic [9:0] mon = {lk2.cpu_run, in_standby2, link.idle_exec, link.int_wake, wake_irq,
    in_halt, in_standby, sys_clk_run, link.osc_stable, link.cpu_run};
  lps_device #(.OSC_START_CYC(OSC), .PLL_LOCK_CYC(PLL)) lps_device_inst (
    .ref_clk, .rst_n, .link(link), .lpm_select_halt, .clock_divider_select,
    .standby_qual_en(1'b0), .standby_qual_count, .xtal_source, .keep_osc_one,
    .keep_osc_two, .keep_watchdog, .flash_asleep, .wake_int_enable, .sys_clk_run,
    .periph_clk_en, .pll_en, .xtal_osc_en, .core_clock_input_en, .internal_osc_one_en,
    .internal_osc_two_en, .watchdog_en, .in_standby, .in_halt, .wake_irq);
  lps_device #(.OSC_START_CYC(OSC), .PLL_LOCK_CYC(PLL)) lps_device_inst2 (
    .ref_clk, .rst_n, .link(lk2), .lpm_select_halt(1'b0), .clock_divider_select,
    .standby_qual_en(1'b1), .standby_qual_count, .xtal_source, .keep_osc_one,
    .keep_osc_two, .keep_watchdog, .flash_asleep, .wake_int_enable, .sys_clk_run(),
    .periph_clk_en(), .pll_en(), .xtal_osc_en(), .core_clock_input_en(),
    .internal_osc_one_en(), .internal_osc_two_en(), .watchdog_en(),
    .in_standby(in_standby2), .in_halt(), .wake_irq());
  lps_host #(.OSC_START_CYC(OSC)) lps_host_inst (
    .ref_clk, .rst_n, .link(link), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  lps_chk #(.OSC_START_CYC(OSC), .PLL_LOCK_CYC(PLL)) lps_chk_inst (
    .ref_clk, .rst_n, .idle_exec(link.idle_exec), .wake_gpio_n(link.wake_gpio_n),
    .device_reset_pin_n(link.device_reset_pin_n), .int_wake(link.int_wake),
    .watchdog_interrupt(link.watchdog_interrupt), .cpu_run(link.cpu_run),
    .osc_stable(link.osc_stable), .external_clock_output(link.external_clock_output));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc_count <= cyc_count + 1;
    if (cyc_count == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_range(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : cmp_range
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read
  // Bounded wait for one monitored bit
  task automatic wait_bit(input int i, input logic v, output int n);
    n = 0;
    while (mon[i] !== v && n < LIMIT) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= LIMIT) cmp_val(32'(mon[i]), 32'(v));
  endtask : wait_bit
  function automatic int flush_of(input logic [1:0] d);
    return int'(d[1] ? (d[0] ? FLUSH_LONG_CYC : FLUSH_MID_CYC) : FLUSH_SHORT_CYC);
  endfunction : flush_of
  task automatic t_regs();
    logic [31:0] d;
    reg_read(WIDTH_OFS, d);
    cmp_val(d, 32'(WIDTH_RST));
    reg_write(WIDTH_OFS, 32'h0005);
    reg_read(WIDTH_OFS, d);
    cmp_val(d, 32'h0005);
    reg_write(CTRL_OFS, 32'h000C);
    reg_read(CTRL_OFS, d);
    cmp_val(d, 32'h000C);
    reg_read(8'h0C, d);
    cmp_val(d, 32'h0);
    reg_read(STAT_OFS, d);
    cmp_val(d & 32'h3, 32'h3);
    $display("Register test done");
  endtask : t_regs
  task automatic t_standby(input logic [1:0] d, input int lim);
    int n;
    clock_divider_select <= d;
    flash_asleep <= (d == 2'h3);
    wake_int_enable <= d[0];
    lpm_select_halt <= 1'b0;
    reg_write(CTRL_OFS, 32'h1);
    wait_bit(7, 1'b1, n);
    wait_bit(7, 1'b0, n);
    lpm_select_halt <= 1'b1;
    wait_bit(2, 1'b0, n);
    cmp_range(n, flush_of(d) - 1, flush_of(d) + 2);
    wait_bit(3, 1'b1, n);
    cmp_val(32'({periph_clk_en, pll_en, watchdog_en, in_halt}), 32'h6);
    reg_write(CTRL_OFS, {28'h0, KIND_INT, 2'h2});
    wait_bit(6, 1'b1, n);
    wait_bit(0, 1'b1, n);
    cmp_range(n, 1, lim);
    cmp_val(32'(wake_irq), 32'(d[0]));
    $display("Standby test done, divider %0d", d);
  endtask : t_standby
  task automatic t_halt(input logic [1:0] k);
    int n;
    clock_divider_select <= k;
    lpm_select_halt <= 1'b1;
    flash_asleep <= (k == 2'h3);
    xtal_source <= (k != 2'h2);
    wake_int_enable <= k[1];
    keep_osc_one <= k[0];
    keep_osc_two <= k[1];
    keep_watchdog <= (k == KIND_WD);
    reg_write(CTRL_OFS, 32'h1);
    wait_bit(7, 1'b1, n);
    wait_bit(7, 1'b0, n);
    wait_bit(2, 1'b0, n);
    cmp_range(n, flush_of(k) - 1, flush_of(k) + 2);
    wait_bit(1, 1'b0, n);
    repeat (2) @(posedge ref_clk);
    cmp_val(32'({in_halt, periph_clk_en, pll_en, xtal_osc_en, core_clock_input_en,
      internal_osc_one_en, internal_osc_two_en, watchdog_en}),
      32'({3'h4, k == 2'h2, 1'h0, k[0], k[1], k == 2'h3}));
    reg_write(CTRL_OFS, {28'h0, k, 2'h2});
    wait_bit(1, 1'b1, n);
    cmp_range(n, OSC, OSC + 6);
    wait_bit(0, 1'b1, n);
    cmp_range(n, PLL, PLL + ((k == 2'h3) ? 1125 : 35));
    cmp_val(32'(wake_irq), 32'(k[1]));
    $display("Halt test done, wake kind %0d", k);
  endtask : t_halt
  task automatic pulse2(input int len);
    @(posedge ref_clk);
    lk2.int_wake <= 1'b1;
    repeat (len) @(posedge ref_clk);
    lk2.int_wake <= 1'b0;
  endtask : pulse2
  task automatic t_qual();
    int n;
    standby_qual_count <= 6'h05;
    flash_asleep <= 1'b0;
    @(posedge ref_clk);
    lk2.idle_exec <= 1'b1;
    @(posedge ref_clk);
    lk2.idle_exec <= 1'b0;
    wait_bit(8, 1'b1, n);
    pulse2(6);
    repeat (200) @(posedge ref_clk);
    cmp_val(32'(mon[9]), 32'h0);
    pulse2(7);
    wait_bit(9, 1'b1, n);
    cmp_range(n, 1, 100);
    $display("Qualified wake test done");
  endtask : t_qual
  initial begin
    lk2.idle_exec = 1'b0;
    lk2.wake_gpio_n = 1'b1;
    lk2.device_reset_pin_n = 1'b1;
    lk2.int_wake = 1'b0;
    lk2.watchdog_interrupt = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    for (int i = 0; i < 4; i++) t_standby(2'(i), (i == 3) ? 1125 : 100);
    for (int i = 0; i < 4; i++) t_halt(2'(i));
    t_qual();
    finish_test();
  end
endmodule : test_low_power_standby_halt_sequencer
`default_nettype wire
